// *** logic/afe_spi_defs.vh ***
// afe_spi_defs.vh: constants of the serial register port
// assumes: included by the port module by its bare name
`ifndef AFE_SPI_DEFS_VH
`define AFE_SPI_DEFS_VH

// command byte 0 layout: addr[6:0] in bits 6..0, direction in bit 7
`define CMD_RW_BIT       7
`define CMD_ADDR_MSB     6
// command byte 1 layout: checksum enable in bit 7, read length in bits 6..0
`define CMD_EC_BIT       7
`define CMD_LEN_MSB      6
`define RW_WRITE         1'b0
`define RW_READ          1'b1
`define CRC_INIT         8'hff
`define CRC_POLY         8'h07
`define ADDR_W           7
`define DATA_W           8

`endif

// *** logic/afe_spi_port.v ***
// afe_spi_port.v: serial slave port for register reads and writes
// assumes: chip select, serial clock and data come from an outside master
// and are sampled on clk_sys; register file sits outside behind regAddr/regWr
`timescale 1ns/1ps
`include "afe_spi_defs.vh"

// Notes on behaviour
// - port accepts clock and data only while chip select is low
// - input bits sampled on rising serial clock, most significant first
// - output bits shifted on falling serial clock, most significant first
// - chip select high disables port and returns framing to idle
// - a write carries exactly one data byte
// - a read returns as many bytes as the command asks
// - direction bit zero writes, one reads
// - checksum enable bit one adds a checksum byte, zero none
// - serial output is high impedance while chip select is high
// - checksum x^8+x^2+x+1, appended, reset to all ones while deselected
// - bad write checksum discards the write and sets error flag
// - read checksum follows data and is not counted in length
module afe_spi_port (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire        chipSelectN,
    input  wire        serialClock,
    input  wire        serialDataIn,
    output reg         serialDataOut,
    output wire        serialDataOutEn,
    output reg  [6:0]  regAddr,
    output reg  [7:0]  regWrData,
    output reg         regWr,
    output reg         regRd,
    input  wire [7:0]  regRdData,
    output reg         crcError,
    input  wire        crcErrorClr
);

    // ****************************************
    // frame states
    // ****************************************
    localparam [2:0] ST_CMD0 = 3'd0;
    localparam [2:0] ST_CMD1 = 3'd1;
    localparam [2:0] ST_WDAT = 3'd2;
    localparam [2:0] ST_WCRC = 3'd3;
    localparam [2:0] ST_RDAT = 3'd4;
    localparam [2:0] ST_RCRC = 3'd5;
    localparam [2:0] ST_DONE = 3'd6;

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg [2:0] csSync_r;
    reg [2:0] sckSync_r;
    reg [2:0] sdiSync_r;
    reg       csN_r;
    reg       sck_r;

    // three stages; a select or clock change counts once stages two and three agree, data is taken from stage three
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            csSync_r  <= 3'h7;
            sckSync_r <= 3'h0;
            sdiSync_r <= 3'h0;
            csN_r     <= 1'b1;
            sck_r     <= 1'b0;
        end else begin
            csSync_r  <= {csSync_r[1:0], chipSelectN};
            sckSync_r <= {sckSync_r[1:0], serialClock};
            sdiSync_r <= {sdiSync_r[1:0], serialDataIn};
            if (csSync_r[1] == csSync_r[2])
                csN_r <= csSync_r[2];
            if (sckSync_r[1] == sckSync_r[2])
                sck_r <= sckSync_r[2];
        end
    end

    wire sckNew  = (sckSync_r[1] == sckSync_r[2]) ? sckSync_r[2] : sck_r;
    wire sckRise = ~csN_r & sckNew & ~sck_r;
    wire sckFall = ~csN_r & ~sckNew & sck_r;
    wire sdiBit  = sdiSync_r[2];

    // ****************************************
    // checksum step, one bit at a time
    // ****************************************
    function [7:0] crcStep;
        input [7:0] crc;
        input       bitIn;
        begin
            crcStep = {crc[6:0], 1'b0} ^ ((crc[7] ^ bitIn) ? `CRC_POLY : 8'h00);
        end
    endfunction

    // ****************************************
    // frame machine
    // ****************************************
    reg [2:0] state_r;
    reg [2:0] bitCnt_r;
    reg [7:0] shiftIn_r;
    reg [7:0] shiftOut_r;
    reg [7:0] crc_r;
    reg       isRead_r;
    reg       crcOn_r;
    reg [6:0] remain_r;
    reg       outArm_r;

    wire [7:0] byteIn  = {shiftIn_r[6:0], sdiBit};
    wire       lastBit = (bitCnt_r == 3'd7);

    // tristate while deselected
    assign serialDataOutEn = ~csN_r;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r       <= ST_CMD0;
            bitCnt_r      <= 3'd0;
            shiftIn_r     <= 8'h00;
            shiftOut_r    <= 8'h00;
            crc_r         <= `CRC_INIT;
            isRead_r      <= 1'b0;
            crcOn_r       <= 1'b0;
            remain_r      <= 7'h00;
            outArm_r      <= 1'b0;
            serialDataOut <= 1'b0;
            regAddr       <= 7'h00;
            regWrData     <= 8'h00;
            regWr         <= 1'b0;
            regRd         <= 1'b0;
            crcError      <= 1'b0;
        end else begin
            regWr <= 1'b0;
            regRd <= 1'b0;
            // clear first so a same-cycle error still sets the flag
            if (crcErrorClr)
                crcError <= 1'b0;
            if (csN_r) begin
                // deselect abandons any partial frame
                state_r       <= ST_CMD0;
                bitCnt_r      <= 3'd0;
                crc_r         <= `CRC_INIT;
                outArm_r      <= 1'b0;
                serialDataOut <= 1'b0;
            end else begin
                // output shift on falling edge, loaded byte armed at byte end
                if (sckFall && outArm_r) begin
                    serialDataOut <= shiftOut_r[7];
                    shiftOut_r    <= {shiftOut_r[6:0], 1'b0};
                end
                if (sckRise) begin
                    shiftIn_r <= byteIn;
                    bitCnt_r  <= bitCnt_r + 3'd1;
                    // checksum covers both directions' bytes on the line;
                    // read bits count as they stand on the output pin
                    if (state_r == ST_RDAT || state_r == ST_RCRC)
                        crc_r <= crcStep(crc_r, serialDataOut);
                    else if (state_r != ST_WCRC && state_r != ST_DONE)
                        crc_r <= crcStep(crc_r, sdiBit);
                    // step the address early so read data is settled at byte end
                    if (state_r == ST_RDAT && bitCnt_r == 3'd0 && remain_r != 7'h01)
                        regAddr <= regAddr + 7'h01;
                    if (lastBit) begin
                        case (state_r)
                            ST_CMD0: begin
                                regAddr  <= byteIn[`CMD_ADDR_MSB:0];
                                isRead_r <= (byteIn[`CMD_RW_BIT] == `RW_READ);
                                state_r  <= ST_CMD1;
                            end
                            ST_CMD1: begin
                                crcOn_r  <= byteIn[`CMD_EC_BIT];
                                remain_r <= byteIn[`CMD_LEN_MSB:0];
                                if (isRead_r) begin
                                    if (byteIn[`CMD_LEN_MSB:0] == 7'h00) begin
                                        // empty read: only the checksum, if enabled
                                        shiftOut_r <= crcStep(crc_r, sdiBit);
                                        outArm_r   <= byteIn[`CMD_EC_BIT];
                                        state_r    <= byteIn[`CMD_EC_BIT] ? ST_RCRC : ST_DONE;
                                    end else begin
                                        regRd      <= 1'b1;
                                        shiftOut_r <= regRdData;
                                        outArm_r   <= 1'b1;
                                        state_r    <= ST_RDAT;
                                    end
                                end else begin
                                    state_r <= ST_WDAT;
                                end
                            end
                            ST_WDAT: begin
                                regWrData <= byteIn;
                                if (crcOn_r) begin
                                    state_r <= ST_WCRC;
                                end else begin
                                    regWr   <= 1'b1;
                                    state_r <= ST_DONE;
                                end
                            end
                            ST_WCRC: begin
                                if (byteIn == crc_r)
                                    regWr <= 1'b1;
                                else
                                    crcError <= 1'b1;
                                state_r <= ST_DONE;
                            end
                            ST_RDAT: begin
                                remain_r <= remain_r - 7'h01;
                                if (remain_r != 7'h01) begin
                                    regRd      <= 1'b1;
                                    shiftOut_r <= regRdData;
                                end else if (crcOn_r) begin
                                    // checksum not counted in length
                                    shiftOut_r <= crcStep(crc_r, serialDataOut);
                                    state_r    <= ST_RCRC;
                                end else begin
                                    outArm_r <= 1'b0;
                                    state_r  <= ST_DONE;
                                end
                            end
                            ST_RCRC: begin
                                outArm_r <= 1'b0;
                                state_r  <= ST_DONE;
                            end
                            default: state_r <= ST_DONE;  // extra bytes ignored
                        endcase
                    end
                end
            end
        end
    end

endmodule

// *** testbench/afe_spi_port_properties.sv ***
// afe_spi_port_properties.sv: port-level checks of the serial register port
// assumes: bound to afe_spi_port, single clk_sys domain
`timescale 1ns/1ps
module afe_spi_port_properties (
    input wire       clk_sys,
    input wire       reset_n,
    input wire       chipSelectN,
    input wire       serialDataOutEn,
    input wire [6:0] regAddr,
    input wire       regWr,
    input wire       regRd,
    input wire       crcError,
    input wire       crcErrorClr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    outOff_a: assert property (chipSelectN [*6] |-> !serialDataOutEn)
        else $error("output driven while deselected");
    idleStrobe_a: assert property (chipSelectN [*8] |-> !regWr && !regRd)
        else $error("strobe while deselected");
    addrIdle_a: assert property (chipSelectN [*8] |-> $stable(regAddr))
        else $error("address moved while deselected");
    wrPulse_a: assert property (regWr |=> !regWr)
        else $error("write strobe longer than one cycle");
    rdPulse_a: assert property (regRd |=> !regRd)
        else $error("read strobe longer than one cycle");
    oneDir_a: assert property (!(regWr && regRd))
        else $error("read and write strobes together");
    errHold_a: assert property (crcError && !crcErrorClr |=> crcError)
        else $error("error flag lost without clear");
    errClear_a: assert property ($fell(crcError) |-> $past(crcErrorClr))
        else $error("error flag fell without clear");
    errNoWr_a: assert property ($rose(crcError) |-> !regWr ##1 !regWr)
        else $error("write done despite bad checksum");
endmodule
bind afe_spi_port afe_spi_port_properties u_afe_spi_port_properties (.clk_sys(clk_sys),
    .reset_n(reset_n), .chipSelectN(chipSelectN), .serialDataOutEn(serialDataOutEn),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .crcError(crcError),
    .crcErrorClr(crcErrorClr));

// *** testbench/spi_master_model.sv ***
// spi_master_model.sv: serial bus master driving the port
// assumes: clk_sys from the bench; link clock 160 ns, idle low between frames
`timescale 1ns/1ps
module spi_master_model (
    input  wire clk_sys,
    output reg  csN,
    output reg  sck,
    output reg  sdi,
    input  wire sdo
);
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // select before clocking starts
    task csLow; begin @(negedge clk_sys); csN = 1'b0; repeat (6) @(negedge clk_sys); end endtask
    // deselect after every operation, data line toggled
    task csHigh; begin
        repeat (6) @(negedge clk_sys);
        csN = 1'b1;
        sdi = ~sdi;
        repeat (12) @(negedge clk_sys);
    end endtask
    // one byte, msb first, data set in low phase, read before the rise
    task xbyte(input [7:0] t, output [7:0] r);
        integer k;
        begin
            for (k = 7; k >= 0; k = k - 1) begin
                sdi = t[k];
                repeat (2) @(negedge clk_sys);
                r[k] = sdo;
                sck = 1'b1;
                repeat (4) @(negedge clk_sys);
                sck = 1'b0;
                repeat (2) @(negedge clk_sys);
            end
        end
    endtask
endmodule

// *** testbench/afe_spi_port_bench.sv ***
// afe_spi_port_bench.sv: self-checking bench of the serial register port
// assumes: register file and expected copy modelled here
`timescale 1ns/1ps
module afe_spi_port_bench;
    reg        clk_sys = 1'b0, reset_n = 1'b0, crcErrorClr = 1'b0;
    wire       csN, sck, sdi, sdo, sdoEn, regWr, regRd, crcError;
    wire [6:0] regAddr;
    wire [7:0] regWrData;
    reg  [7:0] mem [0:127];
    reg  [7:0] expm [0:127];
    reg  [7:0] rx, c, d;
    reg  [6:0] a, ix;
    integer    err_total = 0, n_tests = 0, seed = 63, i, j, rnd, rdPulses = 0;
    always #10 clk_sys = ~clk_sys;
    // register file behind the port
    always @(posedge clk_sys) if (regWr) mem[regAddr] <= regWrData;
    // count read strobes of the current read
    always @(posedge clk_sys) if (regRd) rdPulses <= rdPulses + 1;
    afe_spi_port u_afe_spi_port (.clk_sys(clk_sys), .reset_n(reset_n), .chipSelectN(csN),
        .serialClock(sck), .serialDataIn(sdi), .serialDataOut(sdo), .serialDataOutEn(sdoEn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(mem[regAddr]), .crcError(crcError), .crcErrorClr(crcErrorClr));
    spi_master_model u_spi_master_model (.clk_sys(clk_sys), .csN(csN), .sck(sck), .sdi(sdi),
        .sdo(sdoEn ? sdo : 1'bz));
    function [7:0] crc8(input [7:0] cc, input [7:0] b);
        integer k;
        begin
            for (k = 7; k >= 0; k = k - 1) cc = {cc[6:0], 1'b0} ^ ((cc[7] ^ b[k]) ? 8'h07 : 8'h00);
            crc8 = cc;
        end
    endfunction
    task check(input [7:0] e, input [7:0] s, input [8*8-1:0] nm); begin
        n_tests = n_tests + 1;
        if (s !== e) begin
            err_total = err_total + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, e, s);
        end
    end endtask
    task xb(input [7:0] t); begin u_spi_master_model.xbyte(t, rx); c = crc8(c, t); end endtask
    task wr(input [6:0] ad, input [7:0] dv, input ec, input bad); begin
        c = 8'hff;
        u_spi_master_model.csLow;
        xb({1'b0, ad});
        xb({ec, 7'h01});
        xb(dv);
        if (ec) xb(c ^ {7'h00, bad});
        u_spi_master_model.csHigh;
        if (!(ec && bad)) expm[ad] = dv;
        check(expm[ad], mem[ad], "wrdata");
        check({7'h00, ec && bad}, {7'h00, crcError}, "crcflag");
        $display("write test %h done", ad);
    end endtask
    task rd(input [6:0] ad, input [6:0] n, input ec); begin
        c = 8'hff;
        rdPulses = 0;
        u_spi_master_model.csLow;
        xb({1'b1, ad});
        xb({ec, n});
        for (j = 0; j < n; j = j + 1) begin
            ix = ad + j[6:0];
            u_spi_master_model.xbyte(8'h00, rx);
            check(expm[ix], rx, "rddata");
            c = crc8(c, expm[ix]);
        end
        if (ec) begin u_spi_master_model.xbyte(8'h00, rx); check(c, rx, "rdcrc"); end
        u_spi_master_model.csHigh;
        check({1'b0, n}, rdPulses[7:0], "rdstrobe");
        $display("read test %h done", ad);
    end endtask
    task print_verdict; begin
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    end endtask
    initial begin #2000000; err_total = err_total + 1; print_verdict; end
    initial begin
        for (i = 0; i < 128; i = i + 1) begin mem[i] = 8'h00; expm[i] = 8'h00; end
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        for (i = 0; i < 4; i = i + 1) begin
            rnd = $random(seed);
            a   = rnd[6:0];
            d   = rnd[14:7];
            wr(a, d, i[0], 1'b0);
            rd(a - 7'h01, 7'h03, i[1]);
        end
        // abandoned frame then a clean write
        u_spi_master_model.csLow;
        xb(8'h05);
        u_spi_master_model.csHigh;
        wr(7'h7f, 8'h5a, 1'b0, 1'b0);
        rd(7'h7e, 7'h03, 1'b1);
        wr(7'h10, 8'ha5, 1'b1, 1'b1);
        @(negedge clk_sys) crcErrorClr = 1'b1;
        @(negedge clk_sys) crcErrorClr = 1'b0;
        check(8'h00, {7'h00, crcError}, "crcclr");
        rd(7'h10, 7'h00, 1'b1);
        print_verdict;
    end
endmodule
